// File: adcc_pkg.sv
// shared constants, types and register map of the continuous serial converter block
package adcc_pkg;
   localparam int PCLK_HZ = 10_000_000;
   localparam int CLK_PERIOD_NS = 100;
   localparam int SLEEP_MIN_NS = 500;
   localparam int SLEEP_CYC = (SLEEP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int INT_OSC_HZ = 1_800_000;
   localparam int INT_DIV = PCLK_HZ / INT_OSC_HZ;
   localparam int EXT_DIV = 5;
   localparam int EXT_IDLE_CYC = 64;
   localparam int OSR_MIN = 64;
   localparam int OSR_CODE_MAX = 9;
   localparam int NULL_PER_RESULT = 8;
   localparam int CONV_LEN_MIN = OSR_MIN * NULL_PER_RESULT;
   localparam int OUT_BITS = 32;
   localparam int SEL_BITS = 13;
   localparam int SCK_HALF = 2;
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_STATUS = 12'h004;
   localparam logic [11:0] ADDR_RESULT = 12'h008;
   localparam logic [11:0] ADDR_COUNT = 12'h00c;
   localparam int CTRL_EN_BIT = 0;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_ST_LSB = 1;
   localparam int STAT_OSR_LSB = 3;
   localparam int STAT_CH_LSB = 7;
   localparam int STAT_EXT_BIT = 12;
   localparam int STAT_MODE_BIT = 13;
   localparam logic [3:0] SEL_OSR_RST = 4'h0;
   localparam logic [4:0] SEL_CH_RST = 5'h00;
   typedef struct packed {
      logic [3:0] osr_code;
      logic [4:0] channel;
   } adcc_sel_type;
   typedef struct packed {
      logic sck;
      logic sdo;
      logic busy;
   } adcc_pins_type;
   typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_SLEEP, ST_OUT} adcc_state_type;
endpackage

// File: adcc_tick.sv
// modulator sample tick from internal divider or external conversion clock
`timescale 1ns/1ns
module adcc_tick #(
   parameter int INT_DIV_P = adcc_pkg::INT_DIV,
   parameter int EXT_DIV_P = adcc_pkg::EXT_DIV,
   parameter int IDLE_P = adcc_pkg::EXT_IDLE_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic conv_clk_pin,
   output logic tick,
   output logic ext_active
);
   import adcc_pkg::*;
   logic s1_q, s2_q, s3_q;
   logic [7:0] idle_q, int_q, ext_q;
   logic int_tick_q, ext_tick_q;
   logic pin_edge;
   if (INT_DIV_P < 1 || INT_DIV_P > 255 || EXT_DIV_P < 1 || EXT_DIV_P > 255 || IDLE_P > 255)
   begin : g_chk
      $error("adcc_tick divider out of range");
   end
   assign pin_edge = s2_q & ~s3_q;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end
      else
      begin
         s1_q <= conv_clk_pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   // pin held low long enough falls back to internal oscillator
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         idle_q <= 8'h00;
      else if (pin_edge)
         idle_q <= 8'(IDLE_P);
      else if (idle_q != 8'h00)
         idle_q <= idle_q - 8'h01;
   end
   // external clock divided by five
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ext_q <= 8'h00;
         ext_tick_q <= 1'b0;
      end
      else
      begin
         ext_tick_q <= pin_edge && (ext_q == 8'(EXT_DIV_P - 1));
         if (pin_edge)
            ext_q <= (ext_q == 8'(EXT_DIV_P - 1)) ? 8'h00 : ext_q + 8'h01;
      end
   end
   // nominal internal oscillator rate
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         int_q <= 8'h00;
         int_tick_q <= 1'b0;
      end
      else
      begin
         int_tick_q <= (int_q == 8'(INT_DIV_P - 1));
         int_q <= (int_q == 8'(INT_DIV_P - 1)) ? 8'h00 : int_q + 8'h01;
      end
   end
   assign ext_active = (idle_q != 8'h00);
   assign tick = ext_active ? ext_tick_q : int_tick_q;
endmodule

// File: adcc_shift.sv
// self-clocked serial shifter: drives sck, shifts sdo, captures sdi
`timescale 1ns/1ns
module adcc_shift #(
   parameter int NBITS = adcc_pkg::OUT_BITS,
   parameter int SBITS = adcc_pkg::SEL_BITS,
   parameter int HALF = adcc_pkg::SCK_HALF
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic start,
   input wire logic [NBITS-1:0] word,
   input wire logic sdi_s,
   output logic sck,
   output logic sdo,
   output logic active,
   output logic done,
   output logic sel_valid,
   output logic [SBITS-1:0] sel_word
);
   import adcc_pkg::*;
   logic [NBITS-1:0] sh_q;
   logic [SBITS-1:0] in_q;
   logic [6:0] edges_q;
   logic [3:0] half_q;
   if (NBITS < SBITS || NBITS > 64 || SBITS < 2 || HALF < 1 || HALF > 15)
   begin : g_chk
      $error("adcc_shift parameters out of range");
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         active <= 1'b0;
         sck <= 1'b1;
         sdo <= 1'b1;
         sh_q <= '0;
         in_q <= '0;
         edges_q <= 7'h00;
         half_q <= 4'h0;
         done <= 1'b0;
         sel_valid <= 1'b0;
         sel_word <= '0;
      end
      else
      begin
         done <= 1'b0;
         sel_valid <= 1'b0;
         if (start && !active)
         begin
            active <= 1'b1;
            sck <= 1'b0;
            sdo <= word[NBITS-1];
            sh_q <= word << 1;
            edges_q <= 7'h00;
            half_q <= 4'h0;
         end
         else if (active)
         begin
            half_q <= (half_q == 4'(HALF - 1)) ? 4'h0 : half_q + 4'h1;
            if (half_q == 4'(HALF - 1))
            begin
               if (!sck)
               begin
                  // rising edge, count it
                  sck <= 1'b1;
                  edges_q <= edges_q + 7'h01;
                  if (edges_q == 7'(NBITS - 1))
                  begin
                     active <= 1'b0;
                     done <= 1'b1;
                  end
               end
               else
               begin
                  // data moves only on falling edge
                  sck <= 1'b0;
                  sdo <= sh_q[NBITS-1];
                  sh_q <= sh_q << 1;
                  // input bit of the last rise, taken late for pin and synchroniser delay
                  in_q <= {in_q[SBITS-2:0], sdi_s};
                  if (edges_q == 7'(SBITS))
                  begin
                     sel_valid <= 1'b1;
                     sel_word <= {in_q[SBITS-2:0], sdi_s};
                  end
               end
            end
         end
      end
   end
endmodule

// File: adcc_top.sv
// continuous self-clocked conversion sequencer with apb registers
// What this block does
// - converting holds sck, sdo, busy high
// - completion drops sck, busy, sdo together
// - sleep at least 500 ns, then output
// - output cycle is 32 sck pulses
// - sdo changes on sck falling edges
// - after 32nd rise sdo high, sck high
// - generated shift clock drives sck pin
// - oversample ratio 64 up to 32768
// - first null is sample rate over ratio
// - grounded clock pin uses internal oscillator
// - result rate is null over eight
// - external clock divided by five
// - stay asleep while chip select high
// - sdi held high selects ratio 32768
// - notch halves as ratio doubles
// - result loaded when busy falls
// - new selection needs thirteen input bits
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ns
module adcc_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic clock_source_select_n,
   input wire logic conv_clk_in,
   input wire logic chip_select_n,
   input wire logic sdi,
   input wire logic [23:0] conv_data,
   output logic conv_start,
   output adcc_pkg::adcc_sel_type active_sel,
   output logic sck_out,
   output logic sdo_out,
   output logic busy_out
);
   import adcc_pkg::*;
   adcc_state_type st_q;
   adcc_pins_type pins_q, pins_d;
   adcc_sel_type sel_q, pend_q;
   logic pend_v_q;
   logic [31:0] ctrl_q, result_q, count_q, status_d;
   logic [18:0] tick_cnt_q, conv_len;
   logic [3:0] sleep_q;
   logic [3:0] osr_eff;
   logic mode_s1_q, mode_s_q, cs_s1_q, cs_s_q, sdi_s1_q, sdi_s_q;
   logic tick, ext_active, enable;
   logic sh_start, sh_sck, sh_sdo, sh_active, sh_done, sh_sel_v;
   logic [SEL_BITS-1:0] sh_sel_word;
   logic conv_end, sleep_done, acc, mapped;
   // pin synchronisers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mode_s1_q <= 1'b0;
         mode_s_q <= 1'b0;
         cs_s1_q <= 1'b1;
         cs_s_q <= 1'b1;
         sdi_s1_q <= 1'b0;
         sdi_s_q <= 1'b0;
      end
      else
      begin
         mode_s1_q <= clock_source_select_n;
         mode_s_q <= mode_s1_q;
         cs_s1_q <= chip_select_n;
         cs_s_q <= cs_s1_q;
         sdi_s1_q <= sdi;
         sdi_s_q <= sdi_s1_q;
      end
   end
   adcc_tick u_tick (
      .pclk(pclk),
      .presetn(presetn),
      .conv_clk_pin(conv_clk_in),
      .tick(tick),
      .ext_active(ext_active)
   );
   adcc_shift u_shift (
      .pclk(pclk),
      .presetn(presetn),
      .start(sh_start),
      .word(result_q),
      .sdi_s(sdi_s_q),
      .sck(sh_sck),
      .sdo(sh_sdo),
      .active(sh_active),
      .done(sh_done),
      .sel_valid(sh_sel_v),
      .sel_word(sh_sel_word)
   );
   // ratio code n gives 64 << n, notch halves per step
   assign osr_eff = (sel_q.osr_code > 4'(OSR_CODE_MAX)) ? 4'(OSR_CODE_MAX) : sel_q.osr_code;
   // eight nulls per result, so eight ratios of samples
   assign conv_len = 19'(CONV_LEN_MIN) << osr_eff;
   assign enable = ctrl_q[CTRL_EN_BIT];
   assign conv_end = (st_q == ST_CONV) && tick && (tick_cnt_q == conv_len - 19'h00001);
   assign sleep_done = (sleep_q >= 4'(SLEEP_CYC - 1));
   // leave sleep unprompted once minimum time passed and chip select low
   assign sh_start = (st_q == ST_SLEEP) && sleep_done && !cs_s_q && enable;
   // sequencer
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         st_q <= ST_IDLE;
      else
      begin
         case (st_q)
            ST_IDLE:
               if (enable && mode_s_q)
                  st_q <= ST_CONV;
            ST_CONV:
               if (conv_end)
                  st_q <= ST_SLEEP;
            ST_SLEEP:
               if (!enable)
                  st_q <= ST_IDLE;
               else if (sh_start)
                  st_q <= ST_OUT;
            ST_OUT:
               if (sh_done)
                  st_q <= (enable && mode_s_q) ? ST_CONV : ST_IDLE;
            default:
               st_q <= ST_IDLE;
         endcase
      end
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         tick_cnt_q <= 19'h00000;
      else if (st_q != ST_CONV)
         tick_cnt_q <= 19'h00000;
      else if (tick)
         tick_cnt_q <= tick_cnt_q + 19'h00001;
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sleep_q <= 4'h0;
      else if (st_q != ST_SLEEP)
         sleep_q <= 4'h0;
      else if (!sleep_done)
         sleep_q <= sleep_q + 4'h1;
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         conv_start <= 1'b0;
      else
         conv_start <= (st_q != ST_CONV) && (
            (st_q == ST_IDLE && enable && mode_s_q) || (st_q == ST_OUT && sh_done && enable && mode_s_q));
   end
   // finished result latched as busy falls, flag bit first
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         result_q <= 32'h0000_0000;
         count_q <= 32'h0000_0000;
      end
      else if (conv_end)
      begin
         result_q <= {1'b0, 1'b0, conv_data[23], conv_data, sel_q.channel};
         count_q <= count_q + 32'h0000_0001;
      end
   end
   // selection taken only after thirteen input bits
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pend_q <= '{osr_code: SEL_OSR_RST, channel: SEL_CH_RST};
         pend_v_q <= 1'b0;
         sel_q <= '{osr_code: SEL_OSR_RST, channel: SEL_CH_RST};
      end
      else
      begin
         if (sh_sel_v)
         begin
            pend_q.channel <= sh_sel_word[SEL_BITS-1:SEL_BITS-5];
            // all ones clamps to largest ratio
            pend_q.osr_code <= sh_sel_word[3:0];
            pend_v_q <= 1'b1;
         end
         else if (sh_done)
            pend_v_q <= 1'b0;
         if (sh_done && pend_v_q)
            sel_q <= pend_q;
      end
   end
   assign active_sel = '{osr_code: osr_eff, channel: sel_q.channel};
   // pin levels per state
   always_comb
   begin
      pins_d = '{sck: 1'b1, sdo: 1'b1, busy: 1'b0};
      case (st_q)
         ST_CONV:
            pins_d = '{sck: 1'b1, sdo: 1'b1, busy: 1'b1};
         ST_SLEEP:
            pins_d = '{sck: 1'b0, sdo: 1'b0, busy: 1'b0};
         ST_OUT:
            pins_d = '{sck: sh_sck, sdo: sh_sdo, busy: 1'b0};
         default:
            pins_d = '{sck: 1'b1, sdo: 1'b1, busy: 1'b0};
      endcase
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pins_q <= '{sck: 1'b1, sdo: 1'b1, busy: 1'b0};
      else
         pins_q <= pins_d;
   end
   assign sck_out = pins_q.sck;
   assign sdo_out = pins_q.sdo;
   assign busy_out = pins_q.busy;
   // apb slave, zero wait states
   assign acc = psel && penable;
   assign mapped = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) ||
      (paddr == ADDR_RESULT) || (paddr == ADDR_COUNT);
   assign pready = 1'b1;
   assign pslverr = acc && !mapped;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl_q <= CTRL_RST;
      else if (acc && pwrite && paddr == ADDR_CTRL)
         ctrl_q <= {31'h0, pwdata[CTRL_EN_BIT]};
   end
   always_comb
   begin
      status_d = 32'h0000_0000;
      status_d[STAT_BUSY_BIT] = pins_q.busy;
      status_d[STAT_ST_LSB +: 2] = st_q;
      status_d[STAT_OSR_LSB +: 4] = osr_eff;
      status_d[STAT_CH_LSB +: 5] = sel_q.channel;
      status_d[STAT_EXT_BIT] = ext_active;
      status_d[STAT_MODE_BIT] = mode_s_q;
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (psel && !penable && !pwrite)
      begin
         case (paddr)
            ADDR_CTRL: prdata <= ctrl_q;
            ADDR_STATUS: prdata <= status_d;
            ADDR_RESULT: prdata <= result_q;
            ADDR_COUNT: prdata <= count_q;
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end
   // checks
   logic [6:0] rise_cnt_q;
   logic sh_sck_d_q;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rise_cnt_q <= 7'h00;
         sh_sck_d_q <= 1'b1;
      end
      else
      begin
         sh_sck_d_q <= sh_sck;
         if (sh_start)
            rise_cnt_q <= 7'h00;
         else if (sh_sck && !sh_sck_d_q && sh_active)
            rise_cnt_q <= rise_cnt_q + 7'h01;
      end
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   property p_conv_pins;
      (st_q == ST_CONV) |=> (pins_q.sck && pins_q.sdo && pins_q.busy);
   endproperty
   a_conv_pins: assert property (p_conv_pins) else $error("pins not high in conversion");
   property p_fall_together;
      $fell(pins_q.busy) |-> (!pins_q.sck && !pins_q.sdo);
   endproperty
   a_fall_together: assert property (p_fall_together) else $error("busy fell alone");
   property p_sleep_min;
      $rose(st_q == ST_SLEEP) |-> (st_q == ST_SLEEP) [*5];
   endproperty
   a_sleep_min: assert property (p_sleep_min) else $error("sleep shorter than minimum");
   property p_prompt_out;
      (st_q == ST_SLEEP && sleep_done && !cs_s_q && enable) |=> (st_q == ST_OUT);
   endproperty
   a_prompt_out: assert property (p_prompt_out) else $error("output not started");
   property p_rise_count;
      sh_done |-> (rise_cnt_q == 7'd31);
   endproperty
   a_rise_count: assert property (p_rise_count) else $error("not 32 sck rises");
   property p_sdo_on_fall;
      (sh_active && $changed(sh_sdo)) |-> $fell(sh_sck);
   endproperty
   a_sdo_on_fall: assert property (p_sdo_on_fall) else $error("sdo moved off falling edge");
   property p_after_out;
      sh_done |=> (st_q == ST_CONV || st_q == ST_IDLE) ##1 (pins_q.sdo && pins_q.sck);
   endproperty
   a_after_out: assert property (p_after_out) else $error("sdo or sck not high after output");
   property p_sck_pin;
      (st_q == ST_OUT) |=> (pins_q.sck == $past(sh_sck));
   endproperty
   a_sck_pin: assert property (p_sck_pin) else $error("sck pin not shift clock");
   property p_osr_range;
      (conv_len >= 19'(CONV_LEN_MIN)) && (conv_len <= (19'(CONV_LEN_MIN) << OSR_CODE_MAX));
   endproperty
   a_osr_range: assert property (p_osr_range) else $error("ratio out of range");
   property p_load;
      $rose(st_q == ST_SLEEP) |-> (result_q[28:5] == $past(conv_data));
   endproperty
   a_load: assert property (p_load) else $error("result not loaded");
   property p_cs_sleep;
      (st_q == ST_SLEEP && cs_s_q) |=> (st_q != ST_OUT);
   endproperty
   a_cs_sleep: assert property (p_cs_sleep) else $error("woke with chip select high");
   c_conv_done: cover property ($rose(st_q == ST_SLEEP));
   c_out_done: cover property (sh_done);
   c_new_sel: cover property (sh_done && pend_v_q);
   c_ext_clock: cover property ($rose(ext_active));
endmodule

// File: adcc_rx_model.sv
// host receiver model: shifts in result bits and returns selection bits
`timescale 1ns/1ns
module adcc_rx_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic sck,
   input wire logic sdo,
   input wire logic busy,
   input wire logic [12:0] sel_bits,
   output logic sdi,
   output logic [31:0] rx_word,
   output logic [5:0] rises,
   output logic [7:0] bad_edges
);
   logic sck_q;
   logic sdo_q;
   logic busy_q;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sck_q <= 1'b1;
         sdo_q <= 1'b1;
         busy_q <= 1'b0;
         sdi <= 1'b0;
         rx_word <= 32'h0;
         rises <= 6'h0;
         bad_edges <= 8'h0;
      end
      else
      begin
         sck_q <= sck;
         sdo_q <= sdo;
         busy_q <= busy;
         if (busy_q && !busy)
         begin
            rises <= 6'h0;
            sdi <= sel_bits[12];
         end
         else if (sck && !sck_q && !busy)
         begin
            rx_word <= {rx_word[30:0], sdo};
            rises <= rises + 6'h1;
            // past the selection bits the line keeps changing
            sdi <= (rises < 6'd12) ? sel_bits[4'd11 - rises[3:0]] : ~sdi;
         end
         if (!busy && rises != 6'd0 && rises != 6'd32 && sdo != sdo_q && !(sck_q && !sck))
            bad_edges <= bad_edges + 8'h1;
      end
   end
endmodule

// File: tb.sv
// self-checking bench for the continuous serial converter sequencer
`timescale 1ns/1ns
module tb;
   import adcc_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic clock_source_select_n = 1'b1;
   logic conv_clk_in = 1'b0;
   logic chip_select_n = 1'b0;
   logic sdi;
   logic [23:0] conv_data = 24'h0;
   logic conv_start;
   adcc_sel_type active_sel;
   logic sck_out;
   logic sdo_out;
   logic busy_out;
   logic [12:0] sel_bits = 13'h0;
   logic [31:0] rx_word;
   logic [5:0] rises;
   logic [7:0] bad_edges;
   logic ext_run = 1'b0;
   int cyc = 0;
   int sck_drop = 0;
   int mismatches = 0;
   int cmp_count = 0;
   adcc_top i_adcc_top (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .clock_source_select_n(clock_source_select_n), .conv_clk_in(conv_clk_in), .chip_select_n(chip_select_n),
      .sdi(sdi), .conv_data(conv_data), .conv_start(conv_start), .active_sel(active_sel), .sck_out(sck_out),
      .sdo_out(sdo_out), .busy_out(busy_out));
   adcc_rx_model i_adcc_rx_model (.pclk(pclk), .presetn(presetn), .sck(sck_out), .sdo(sdo_out), .busy(busy_out),
      .sel_bits(sel_bits), .sdi(sdi), .rx_word(rx_word), .rises(rises), .bad_edges(bad_edges));
   always #50 pclk = ~pclk;
   // cycle count and external conversion clock at a quarter of pclk
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (ext_run && cyc[0])
         conv_clk_in <= ~conv_clk_in;
   end
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] r,
      output logic e);
      @(posedge pclk);
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      psel <= 1'b1;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // waits for busy level, counting edges and sck drops while converting
   task automatic wait_busy(input logic lvl, input int lim, output int n);
      n = 0;
      while (busy_out !== lvl && n < lim)
      begin
         @(posedge pclk);
         n++;
         if (busy_out === 1'b1 && sck_out !== 1'b1)
            sck_drop++;
      end
      if (n >= lim)
         chk("busy_wait", {31'h0, lvl}, {31'h0, busy_out});
   endtask
   task automatic one_cycle(input logic [4:0] ch, input int len, input int tol, input int hold,
      input logic [31:0] stat);
      int n;
      int t0;
      logic [31:0] exp;
      logic [31:0] r;
      logic e;
      wait_busy(1'b1, 20, n);
      chk("conv_pins", 32'h3, {30'h0, sck_out, sdo_out});
      wait_busy(1'b0, 12_000, n);
      t0 = cyc;
      exp = {2'b00, conv_data[23], conv_data, ch};
      chk("conv_len", 32'h1, {31'h0, n >= len - tol && n <= len + tol});
      chk("sleep_pins", 32'h0, {30'h0, sck_out, sdo_out});
      if (hold > 0)
      begin
         apb(ADDR_STATUS, 1'b0, 32'h0, r, e);
         chk("status_sleep", stat, r);
         while (cyc - t0 < hold)
            @(posedge pclk);
         chk("sck_held", 32'h0, {31'h0, sck_out});
         chip_select_n <= 1'b0;
      end
      while (sck_out !== 1'b1 && cyc - t0 < hold + 100)
         @(posedge pclk);
      n = cyc - t0;
      chk("sleep_len", 32'h1, {31'h0, n >= hold + SLEEP_CYC && n <= hold + SLEEP_CYC + 8});
      wait_busy(1'b1, 300, n);
      @(posedge pclk);
      chk("rise_count", 32'd32, {26'h0, rises});
      chk("rx_word", exp, rx_word);
      chk("end_pins", 32'h3, {30'h0, sck_out, sdo_out});
      chk("edge_faults", 32'h0, {24'h0, bad_edges});
      chk("sck_drops", 32'h0, sck_drop);
   endtask
   task automatic t_reset;
      logic [31:0] r;
      logic e;
      chk("rst_pins", 32'h6, {29'h0, sck_out, sdo_out, busy_out});
      chk("rst_sel", {23'h0, SEL_OSR_RST, SEL_CH_RST}, {23'h0, active_sel});
      apb(ADDR_CTRL, 1'b0, 32'h0, r, e);
      chk("ctrl_rst", CTRL_RST, r);
      apb(ADDR_STATUS, 1'b1, 32'hffff_ffff, r, e);
      apb(ADDR_STATUS, 1'b0, 32'h0, r, e);
      chk("status_idle", (32'(SEL_OSR_RST) << STAT_OSR_LSB) | (32'h1 << STAT_MODE_BIT), r);
      apb(12'h010, 1'b0, 32'h0, r, e);
      chk("unmapped_err", 32'h1, {31'h0, e});
      chk("unmapped_data", 32'h0, r);
   endtask
   // first conversion runs at the reset ratio code
   task automatic t_first;
      logic [31:0] r;
      logic e;
      int n;
      conv_data <= 24'h9a5c33;
      sel_bits <= 13'h0500;
      apb(ADDR_CTRL, 1'b1, 32'h1, r, e);
      n = 0;
      while (conv_start !== 1'b1 && n < 8)
      begin
         @(posedge pclk);
         n++;
      end
      chk("conv_start", 32'h1, {31'h0, conv_start});
      one_cycle(5'h00, (CONV_LEN_MIN << SEL_OSR_RST) * INT_DIV, 15, 0, 32'h0);
      chk("sel_new", {23'h0, 4'h0, 5'h05}, {23'h0, active_sel});
      apb(ADDR_RESULT, 1'b0, 32'h0, r, e);
      chk("result_reg", {3'b001, 24'h9a5c33, 5'h00}, r);
   endtask
   task automatic t_internal;
      logic [31:0] r;
      logic e;
      conv_data <= 24'h80a001;
      sel_bits <= 13'h0300;
      one_cycle(5'h05, CONV_LEN_MIN * INT_DIV, 15, 0, 32'h0);
      chk("sel_ch3", {23'h0, 4'h0, 5'h03}, {23'h0, active_sel});
      apb(ADDR_COUNT, 1'b0, 32'h0, r, e);
      chk("count_reg", 32'h2, r);
      ext_run <= 1'b1;
   endtask
   task automatic t_ext_sleep;
      logic [31:0] stat;
      stat = (32'h2 << STAT_ST_LSB) | (32'h3 << STAT_CH_LSB) | (32'h1 << STAT_EXT_BIT) | (32'h1 << STAT_MODE_BIT);
      conv_data <= 24'h012345;
      sel_bits <= 13'h1fff;
      chip_select_n <= 1'b1;
      one_cycle(5'h03, CONV_LEN_MIN * EXT_DIV * 4, 60, 40, stat);
      chk("sel_max", {23'h0, 4'h9, 5'h1f}, {23'h0, active_sel});
      ext_run <= 1'b0;
   endtask
   initial
   begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      t_reset();
      t_first();
      t_internal();
      t_ext_sleep();
      give_verdict();
   end
   // whole run takes about 16 thousand cycles
   initial
   begin
      repeat (30_000) @(posedge pclk);
      mismatches++;
      give_verdict();
   end
endmodule
